// ==== logic/ssp_pkg.sv ====
/*
 * Shared constants of the serial port unit in its SPI mode: mode field
 * codes, status field positions, reset values and clock divider counts.
 * Assumes the system clock is the unit's oscillator clock.
 */
package ssp_pkg;

	// ------------------------------------------------------------------
	// Mode field codes
	// ------------------------------------------------------------------
	localparam logic [3:0] MODE_DIV4     = 4'h0;
	localparam logic [3:0] MODE_DIV16    = 4'h1;
	localparam logic [3:0] MODE_DIV64    = 4'h2;
	localparam logic [3:0] MODE_TIMER    = 4'h3;
	localparam logic [3:0] MODE_SLV_SS   = 4'h4;
	localparam logic [3:0] MODE_SLV_FREE = 4'h5;
	localparam logic [3:0] MODE_RELOAD   = 4'hA;

	// ------------------------------------------------------------------
	// Status register layout and reset values
	// ------------------------------------------------------------------
	localparam int         STAT_SMP_POS = 7;
	localparam int         STAT_CKE_POS = 6;
	localparam int         STAT_BF_POS  = 0;
	localparam logic       SMP_RESET    = 1'b0;
	localparam logic       CKE_RESET    = 1'b0;
	localparam logic [7:0] BYTE_RESET   = 8'h00;

	// ------------------------------------------------------------------
	// Bit timing
	// ------------------------------------------------------------------
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	// Half-edges of SCK per byte; the extra count closes the last half bit
	localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
	// SCK half periods in system clocks for the fixed divider rates
	localparam logic [9:0] HALF_DIV4  = 10'h002;
	localparam logic [9:0] HALF_DIV16 = 10'h008;
	localparam logic [9:0] HALF_DIV64 = 10'h020;

endpackage : ssp_pkg

// ==== logic/ssp_spi_port.sv ====
/*
 * SPI mode of the serial port unit: shift register, receive buffer,
 * status flags, master SCK generation and slave shifting from SCK.
 * Assumes software strobes arrive as one-cycle pulses on clk_in and that
 * the pins SCK, SDI and SS come from outside and are synchronised here.
 */
`timescale 1ns/1ps
module ssp_spi_port
	import ssp_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	// Control register one fields
	input  wire logic       port_enable_bit_in,
	input  wire logic       clock_idle_polarity_in,
	input  wire logic [3:0] port_mode_field_in,
	input  wire logic       write_collision_clear_in,
	input  wire logic       receive_overflow_clear_in,
	// Control register three field
	input  wire logic       buffer_overwrite_enable_in,
	input  wire logic [7:0] rate_reload_value_in,
	// Status register access
	input  wire logic       status_wr_in,
	input  wire logic [7:0] status_wdata_in,
	output logic      [7:0] port_status_reg_out,
	// Data buffer access
	input  wire logic       buffer_wr_in,
	input  wire logic [7:0] buffer_wdata_in,
	input  wire logic       buffer_rd_in,
	output logic      [7:0] data_buffer_out,
	// Flags
	output logic            buffer_full_flag_out,
	output logic            write_collision_flag_out,
	output logic            receive_overflow_flag_out,
	output logic            transfer_irq_flag_out,
	input  wire logic       transfer_irq_clear_in,
	output logic            busy_out,
	// Period timer tick, same clock domain
	input  wire logic       period_timer_tick_in,
	// Pins
	input  wire logic       serial_clock_pin_in,
	output logic            serial_clock_pin_out,
	output logic            serial_clock_pin_oe_out,
	input  wire logic       sdi_in,
	output logic            sdo_out,
	output logic            sdo_oe_out,
	input  wire logic       ss_n_in
);

	// ------------------------------------------------------------------
	// Pin synchronisers and mode decode
	// ------------------------------------------------------------------
	logic [2:0] pins_s;
	logic       sck_s;
	logic       sdi_s;
	logic       ss_n_s;

	ssp_sync2 #(
		.WIDTH (3)
	) u_pin_sync (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.async_in ({serial_clock_pin_in, sdi_in, ss_n_in}),
		.sync_out (pins_s)
	);

	assign sck_s  = pins_s[2];
	assign sdi_s  = pins_s[1];
	assign ss_n_s = pins_s[0];

	logic en;
	logic is_master;
	logic is_slave;
	logic ss_ctl;

	assign en        = port_enable_bit_in;
	assign is_master = (port_mode_field_in[3:2] == 2'b00) ||
	                   (port_mode_field_in == MODE_RELOAD);
	assign is_slave  = (port_mode_field_in[3:1] == MODE_SLV_SS[3:1]);
	assign ss_ctl    = (port_mode_field_in == MODE_SLV_SS);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		M_IDLE = 2'b01,
		M_RUN  = 2'b10
	} ssp_mstate_t;

	ssp_mstate_t mstate_q, mstate_d;
	logic [7:0]  sr_q, sr_d;
	logic [7:0]  buf_q, buf_d;
	logic        bf_q, bf_d;
	logic        write_collision_flag_q, write_collision_flag_d;
	logic        ovf_q, ovf_d;
	logic        irq_q, irq_d;
	logic        smp_q, smp_d;
	logic        cke_q, cke_d;
	logic        sdo_q, sdo_d;
	logic        phase_q, phase_d;
	logic [4:0]  edge_q, edge_d;
	logic [3:0]  cnt_q, cnt_d;
	logic [9:0]  div_q, div_d;
	logic        sck_prev_q, sck_prev_d;
	logic        ss_prev_q, ss_prev_d;
	logic        pend_samp_q, pend_samp_d;
	logic        pend_outg_q, pend_outg_d;

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	logic [9:0] half_len;
	logic       tick;
	logic       busy;
	logic       wr_ok;
	logic       samp;
	logic       outg;
	logic       samp_nom;
	logic       samp_shift;
	logic       rx_done;
	logic [7:0] sr_n;
	logic       lead;
	logic       trail;
	logic       sel;

	always_comb begin
		case (port_mode_field_in)
			MODE_DIV16:  half_len = HALF_DIV16;
			MODE_DIV64:  half_len = HALF_DIV64;
			MODE_RELOAD: half_len = {1'b0, rate_reload_value_in, 1'b0} +
			                        HALF_DIV4;
			default:     half_len = HALF_DIV4;
		endcase
	end

	// Timer mode toggles SCK once per tick, giving half the timer rate
	assign tick = (port_mode_field_in == MODE_TIMER) ? period_timer_tick_in
	              : (div_q == half_len - 10'h001);
	assign busy = en && (is_master ? (mstate_q == M_RUN || pend_samp_q ||
	                                  pend_outg_q)
	                               : (cnt_q != 4'h0));
	assign sel  = !ss_ctl || !ss_n_s;

	always_comb begin
		mstate_d   = mstate_q;
		sr_d       = sr_q;
		buf_d      = buf_q;
		bf_d       = bf_q;
		write_collision_flag_d     = write_collision_flag_q;
		ovf_d      = ovf_q;
		irq_d      = irq_q;
		smp_d      = smp_q;
		cke_d      = cke_q;
		sdo_d      = sdo_q;
		phase_d    = phase_q;
		edge_d     = edge_q;
		cnt_d      = cnt_q;
		div_d      = div_q;
		sck_prev_d = sck_s;
		ss_prev_d  = ss_n_s;
		pend_samp_d = 1'b0;
		pend_outg_d = 1'b0;
		rx_done    = 1'b0;
		samp       = 1'b0;
		outg       = 1'b0;
		samp_nom   = 1'b0;
		samp_shift = 1'b0;
		lead       = 1'b0;
		trail      = 1'b0;
		sr_n       = sr_q;

		// Only the sampling phase and edge select take a write
		if (status_wr_in) begin
			smp_d = status_wdata_in[STAT_SMP_POS];
			cke_d = status_wdata_in[STAT_CKE_POS];
		end

		// Clears first so that a same-cycle hardware set wins
		if (write_collision_clear_in)
			write_collision_flag_d = 1'b0;
		if (receive_overflow_clear_in)
			ovf_d = 1'b0;
		if (transfer_irq_clear_in)
			irq_d = 1'b0;
		if (buffer_rd_in)
			bf_d = 1'b0;

		wr_ok = buffer_wr_in && !busy && !write_collision_flag_q &&
		        (buffer_overwrite_enable_in || !bf_q);
		if (buffer_wr_in && busy)
			write_collision_flag_d = 1'b1;

		if (!en) begin
			mstate_d = M_IDLE;
			cnt_d    = 4'h0;
			edge_d   = 5'h00;
			div_d    = 10'h000;
			phase_d  = 1'b0;
		end else if (is_master) begin
			// SDI keeps being sampled even if SDO is unused
			if (pend_samp_q) begin
				sr_n  = {sr_q[6:0], sdi_s};
				sr_d  = sr_n;
				cnt_d = cnt_q + 4'h1;
				if (cnt_q == BITS_PER_BYTE - 4'h1) begin
					rx_done = 1'b1;
					cnt_d   = 4'h0;
				end
			end
			if (pend_outg_q)
				sdo_d = sr_n[7];
			if (mstate_q == M_IDLE) begin
				div_d   = 10'h000;
				phase_d = 1'b0;
				if (wr_ok) begin
					mstate_d = M_RUN;
					edge_d   = 5'h00;
					cnt_d    = 4'h0;
				end
			end else begin
				div_d = tick ? 10'h000 : div_q + 10'h001;
				if (tick) begin
					// Even half-edges leave idle, odd ones return to it
					samp_nom   = cke_q ? !edge_q[0] : edge_q[0];
					samp_shift = (cke_q ? edge_q[0] : !edge_q[0]) &&
					             (edge_q != 5'h00);
					samp = (smp_q ? samp_shift
					       : (samp_nom && edge_q < EDGES_PER_BYTE)) &&
					       (cnt_q < BITS_PER_BYTE);
					outg = (cke_q ? edge_q[0] : !edge_q[0]) &&
					       (edge_q < EDGES_PER_BYTE);
					if (edge_q < EDGES_PER_BYTE)
						phase_d = !phase_q;
					// Act a cycle late: synchronised SDI lags SCK at Fosc/4
					pend_samp_d = samp;
					pend_outg_d = outg;
					if (edge_q == EDGES_PER_BYTE)
						mstate_d = M_IDLE;
					edge_d = edge_q + 5'h01;
				end
			end
		end else if (is_slave) begin
			mstate_d = M_IDLE;
			lead  = (sck_s != clock_idle_polarity_in) &&
			        (sck_prev_q == clock_idle_polarity_in);
			trail = (sck_s == clock_idle_polarity_in) &&
			        (sck_prev_q != clock_idle_polarity_in);
			samp  = cke_q ? lead : trail;
			outg  = cke_q ? trail : lead;
			if (ss_ctl && ss_n_s) begin
				cnt_d = 4'h0;
			end else if (sel) begin
				// Shifts on SCK edges seen through the synchroniser on clk_in; no sleep gating exists
				if (samp) begin
					sr_n  = {sr_q[6:0], sdi_s};
					sr_d  = sr_n;
					cnt_d = cnt_q + 4'h1;
					if (cnt_q == BITS_PER_BYTE - 4'h1) begin
						rx_done = 1'b1;
						cnt_d   = 4'h0;
					end
				end
				if (outg)
					sdo_d = sr_n[7];
				// Select edge presents the MSB before any SCK edge
				if (ss_ctl && ss_prev_q && !ss_n_s)
					sdo_d = sr_q[7];
			end
		end

		if (wr_ok) begin
			buf_d = buffer_wdata_in;
			sr_d  = buffer_wdata_in;
			sdo_d = buffer_wdata_in[7];
		end

		if (rx_done) begin
			irq_d = 1'b1;
			if (bf_q && !buffer_rd_in && !buffer_overwrite_enable_in) begin
				ovf_d = 1'b1;
			end else begin
				buf_d = sr_n;
				bf_d  = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			mstate_q   <= M_IDLE;
			sr_q       <= BYTE_RESET;
			buf_q      <= BYTE_RESET;
			bf_q       <= 1'b0;
			write_collision_flag_q     <= 1'b0;
			ovf_q      <= 1'b0;
			irq_q      <= 1'b0;
			smp_q      <= SMP_RESET;
			cke_q      <= CKE_RESET;
			sdo_q      <= 1'b0;
			phase_q    <= 1'b0;
			edge_q     <= 5'h00;
			cnt_q      <= 4'h0;
			div_q      <= 10'h000;
			sck_prev_q <= 1'b0;
			ss_prev_q  <= 1'b1;
			pend_samp_q <= 1'b0;
			pend_outg_q <= 1'b0;
		end else begin
			mstate_q   <= mstate_d;
			sr_q       <= sr_d;
			buf_q      <= buf_d;
			bf_q       <= bf_d;
			write_collision_flag_q     <= write_collision_flag_d;
			ovf_q      <= ovf_d;
			irq_q      <= irq_d;
			smp_q      <= smp_d;
			cke_q      <= cke_d;
			sdo_q      <= sdo_d;
			phase_q    <= phase_d;
			edge_q     <= edge_d;
			cnt_q      <= cnt_d;
			div_q      <= div_d;
			sck_prev_q <= sck_prev_d;
			ss_prev_q  <= ss_prev_d;
			pend_samp_q <= pend_samp_d;
			pend_outg_q <= pend_outg_d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	always_comb begin
		port_status_reg_out               = 8'h00;
		port_status_reg_out[STAT_SMP_POS] = smp_q;
		port_status_reg_out[STAT_CKE_POS] = cke_q;
		port_status_reg_out[STAT_BF_POS]  = bf_q;
	end

	assign data_buffer_out           = buf_q;
	assign buffer_full_flag_out      = bf_q;
	assign write_collision_flag_out  = write_collision_flag_q;
	assign receive_overflow_flag_out = ovf_q;
	assign transfer_irq_flag_out     = irq_q;
	assign busy_out                  = busy;

	// SCK rests at the idle polarity; phase only flips during a byte
	assign serial_clock_pin_out    = clock_idle_polarity_in ^ phase_q;
	assign serial_clock_pin_oe_out = en && is_master;
	assign sdo_out                 = sdo_q;
	// High SS releases SDO two clocks after the pin, through the synchroniser, mid-byte included
	assign sdo_oe_out = en && (is_master || (is_slave && sel));

endmodule : ssp_spi_port

// ==== logic/ssp_sync2.sv ====
/*
 * Two flip-flop synchroniser for a group of unrelated level inputs.
 * Assumes each bit is independent; no bus coherence is implied.
 */
`timescale 1ns/1ps
module ssp_sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;

endmodule : ssp_sync2

// ==== testbench/ssp_spi_partner.sv ====
/* Far-side SPI device: slave to the unit's master clock, or master
   clocking the unit at an 800 ns link period. Bench picks the role. */
`timescale 1ns/1ps
module ssp_spi_partner (
	input  wire logic sck_in,
	input  wire logic sdo_in,
	input  wire logic cpol_in,
	input  wire logic cpha_in,
	input  wire logic master_in,
	output logic      sck_out,
	output logic      ss_n_out,
	output logic      sdi_out
);
	logic [7:0] s_sr = 8'h00, s_rx = 8'h00, m_rx = 8'h00;
	logic       s_bit = 1'b0, m_mosi = 1'b0, m_sck = 1'b0;
	initial ss_n_out = 1'b1;
	// Clock stands at its idle level outside frames
	assign sck_out = ss_n_out ? cpol_in : m_sck;
	assign sdi_out = master_in ? m_mosi : s_bit;
	task automatic load(input logic [7:0] b);
		s_sr = b;
		s_bit = b[7];
	endtask : load
	always @(sck_in) begin
		if (!master_in) begin
			if ((sck_in !== cpol_in) ^ cpha_in) begin
				s_rx = {s_rx[6:0], sdo_in};
			end else begin
				if (!cpha_in) s_sr = s_sr << 1;
				s_bit = s_sr[7];
				if (cpha_in) s_sr = s_sr << 1;
			end
		end
	end
	task automatic xfer(input logic [7:0] b, input int n);
		m_sck = cpol_in;
		#37;
		m_mosi = b[7];
		ss_n_out = 1'b0;
		for (int i = 0; i < n; i++) begin
			#400;
			m_rx = {m_rx[6:0], sdo_in};
			m_sck = ~cpol_in;
			#400;
			m_sck = cpol_in;
			b = b << 1;
			m_mosi = b[7];
		end
		#400;
		ss_n_out = 1'b1;
		// Released line: inverse of its last value
		m_mosi = ~m_mosi;
	endtask : xfer
endmodule : ssp_spi_partner

// ==== testbench/ssp_spi_port_properties.sv ====
/* Port checker of the SPI serial port unit.
   Assumes it is bound to ssp_spi_port and sees only its ports. */
`timescale 1ns/1ps
module ssp_spi_checker
	import ssp_pkg::*;
(
	input wire logic       clk_in,
	input wire logic       rst_in,
	input wire logic       port_enable_bit_in,
	input wire logic       clock_idle_polarity_in,
	input wire logic [3:0] port_mode_field_in,
	input wire logic       buffer_overwrite_enable_in,
	input wire logic       status_wr_in,
	input wire logic [7:0] status_wdata_in,
	input wire logic [7:0] port_status_reg_out,
	input wire logic       buffer_wr_in,
	input wire logic [7:0] buffer_wdata_in,
	input wire logic [7:0] data_buffer_out,
	input wire logic       buffer_full_flag_out,
	input wire logic       write_collision_flag_out,
	input wire logic       transfer_irq_flag_out,
	input wire logic       busy_out,
	input wire logic       serial_clock_pin_out,
	input wire logic       serial_clock_pin_oe_out,
	input wire logic       sdo_out,
	input wire logic       sdo_oe_out,
	input wire logic       ss_n_in
);
	logic take;
	// ----------------------------------------
	// Accepted buffer write
	// ----------------------------------------
	assign take = buffer_wr_in && port_enable_bit_in && !busy_out
		&& !write_collision_flag_out
		&& (buffer_overwrite_enable_in || !buffer_full_flag_out);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	sequence s_div4_go;
		take && port_mode_field_in == MODE_DIV4;
	endsequence
	sequence s_div4_frame;
		##1 busy_out [*8] ##[20:30] !busy_out;
	endsequence
	a_status_wr: assert property (status_wr_in |=>
		port_status_reg_out[7:6] == $past(status_wdata_in[7:6]))
		else $error("status control bits not stored");
	a_status_ro: assert property (
		port_status_reg_out[5:0] == {5'h00, buffer_full_flag_out})
		else $error("status low bits wrong");
	a_write_load: assert property (take |=>
		data_buffer_out == $past(buffer_wdata_in)
		&& sdo_out == $past(buffer_wdata_in[7]))
		else $error("write not loaded");
	a_write_collision_flag_set: assert property (
		buffer_wr_in && port_enable_bit_in && busy_out
		|=> write_collision_flag_out) else $error("no collision flag");
	a_sck_idle: assert property (
		serial_clock_pin_oe_out && !busy_out
		|-> serial_clock_pin_out == clock_idle_polarity_in)
		else $error("clock not at idle level");
	a_sck_drive: assert property (serial_clock_pin_oe_out ==
		(port_enable_bit_in && (port_mode_field_in[3:2] == 2'b00
		|| port_mode_field_in == MODE_RELOAD)))
		else $error("clock direction wrong");
	a_ss_float: assert property (
		(port_mode_field_in == MODE_SLV_SS && ss_n_in) [*4]
		|-> !sdo_oe_out) else $error("data out driven while deselected");
	a_master_time: assert property (s_div4_go |-> s_div4_frame)
		else $error("fast master frame length wrong");
	a_byte_done: assert property (
		$fell(busy_out) && serial_clock_pin_oe_out
		|-> transfer_irq_flag_out) else $error("byte end without flag");
endmodule : ssp_spi_checker
bind ssp_spi_port ssp_spi_checker i_ssp_spi_checker (.*);

// ==== testbench/tb_ssp_spi_port.sv ====
/* Bench of the SPI serial port unit: master at all rates, collisions,
   slave frames. Assumes the partner model and the package. */
`timescale 1ns/1ps
module tb_ssp_spi_port;
	import ssp_pkg::*;
	logic clk_in = 1'b0, rst_in = 1'b1, en = 1'b0, pol = 1'b0, ovw = 1'b0;
	logic swr = 1'b0, bwr = 1'b0, brd = 1'b0, wclr = 1'b0, oclr = 1'b0;
	logic iclr = 1'b0, tick = 1'b0, cke = 1'b0, pm = 1'b0;
	logic [1:0] tcnt = 2'h0;
	logic [3:0] mode = 4'h0;
	logic [3:0] ms [5] = '{MODE_DIV4, MODE_DIV16, MODE_DIV64, MODE_TIMER,
		MODE_RELOAD};
	logic [7:0] rl = 8'h00, swd = 8'h00, bwd = 8'h00, stat, dbuf;
	logic bf, write_collision_flag, ovf, irq, busy, sck_o, sck_oe, sdo, sdo_oe;
	logic p_sck, sdi, ss_n, sck_w;
	int err_count = 0, checks = 0;
	assign sck_w = sck_oe ? sck_o : p_sck;
	always #50 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		tcnt <= tcnt + 2'h1;
		tick <= (tcnt == 2'h3);
	end
	ssp_spi_port i_ssp_spi_port (.clk_in, .rst_in,
		.port_enable_bit_in(en), .clock_idle_polarity_in(pol),
		.port_mode_field_in(mode), .write_collision_clear_in(wclr),
		.receive_overflow_clear_in(oclr), .buffer_overwrite_enable_in(ovw),
		.rate_reload_value_in(rl), .status_wr_in(swr),
		.status_wdata_in(swd), .port_status_reg_out(stat),
		.buffer_wr_in(bwr), .buffer_wdata_in(bwd), .buffer_rd_in(brd),
		.data_buffer_out(dbuf), .buffer_full_flag_out(bf),
		.write_collision_flag_out(write_collision_flag), .receive_overflow_flag_out(ovf),
		.transfer_irq_flag_out(irq), .transfer_irq_clear_in(iclr),
		.busy_out(busy), .period_timer_tick_in(tick),
		.serial_clock_pin_in(sck_w), .serial_clock_pin_out(sck_o),
		.serial_clock_pin_oe_out(sck_oe), .sdi_in(sdi), .sdo_out(sdo),
		.sdo_oe_out(sdo_oe), .ss_n_in(ss_n));
	ssp_spi_partner i_ssp_spi_partner (.sck_in(sck_w), .sdo_in(sdo),
		.cpol_in(pol), .cpha_in(~cke), .master_in(pm), .sck_out(p_sck),
		.ss_n_out(ss_n), .sdi_out(sdi));
	task automatic stop_test();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : stop_test
	task automatic chk(input string nm, input logic [7:0] e, g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	function automatic logic rate_ok(input int n, input logic [3:0] m);
		int h;
		case (m)
			MODE_DIV4: h = 2;
			MODE_DIV16: h = 8;
			MODE_DIV64: h = 32;
			MODE_TIMER: h = 4;
			default: h = 2 * (rl + 1);
		endcase
		return n >= 16 * h - 2 && n <= 18 * h + 2;
	endfunction : rate_ok
	// ----------------------------------------
	// Drivers
	// ----------------------------------------
	task automatic cfg(input logic [3:0] m, input logic c, k, s);
		@(posedge clk_in);
		en <= 1'b0;
		mode <= m;
		pol <= c;
		pm <= m[2];
		rl <= 8'($urandom_range(3));
		swr <= 1'b1;
		swd <= {s, k, 6'h3F};
		@(posedge clk_in);
		swr <= 1'b0;
		cke <= k;
		repeat (4) @(posedge clk_in);
		en <= 1'b1;
		repeat (4) @(posedge clk_in);
		#1;
	endtask : cfg
	task automatic wr(input logic [7:0] b);
		@(posedge clk_in);
		bwr <= 1'b1;
		bwd <= b;
		@(posedge clk_in);
		bwr <= 1'b0;
		#1;
	endtask : wr
	task automatic clr();
		@(posedge clk_in);
		{brd, iclr, wclr, oclr} <= 4'hF;
		@(posedge clk_in);
		{brd, iclr, wclr, oclr} <= 4'h0;
		#1;
	endtask : clr
	task automatic idle(output int n);
		n = 0;
		do begin
			@(posedge clk_in);
			#1;
			n++;
		end while (busy !== 1'b0 && n < 5000);
		if (n >= 5000) begin
			err_count++;
			stop_test();
		end
	endtask : idle
	task automatic sx(input logic [7:0] b, input int n);
		i_ssp_spi_partner.xfer(b, n);
		repeat (6) @(posedge clk_in);
		#1;
	endtask : sx
	initial begin
		repeat (90000) @(posedge clk_in);
		err_count++;
		stop_test();
	end
	initial begin
		logic [7:0] tx, rb;
		int n;
		void'($urandom(32'h7db9));
		repeat (20) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		#1;
		chk("reset", 8'h00, stat | dbuf | {bf, write_collision_flag, ovf, irq});
		cfg(MODE_DIV4, 1'b0, 1'b1, 1'b1);
		chk("status", 8'hC0, stat);
		for (int i = 0; i < 10; i++) begin
			tx = 8'($urandom);
			rb = 8'($urandom);
			cfg(ms[i % 5], 1'($urandom), i < 5, 1'($urandom));
			i_ssp_spi_partner.load(rb);
			wr(tx);
			wr(~tx);
			chk("write_collision_flag", 8'h01, write_collision_flag);
			idle(n);
			chk("rate", 8'h01, rate_ok(n, ms[i % 5]));
			chk("rx", rb, dbuf);
			chk("tx", tx, i_ssp_spi_partner.s_rx);
			chk("bf irq", 8'h03, {bf, irq});
			wr(8'h5A);
			chk("blocked", rb, dbuf);
			clr();
			chk("cleared", 8'h00, {bf, write_collision_flag, irq});
		end
		cfg(MODE_SLV_SS, 1'($urandom), 1'b1, 1'b0);
		wr(tx);
		sx(rb, 8);
		chk("slave rx", rb, dbuf);
		chk("slave tx", tx, i_ssp_spi_partner.m_rx);
		chk("slave irq", 8'h03, {bf, irq});
		wr(~rb);
		chk("unread", rb, dbuf);
		@(posedge clk_in);
		ovw <= 1'b1;
		wr(tx);
		chk("overwrite", tx, dbuf);
		@(posedge clk_in);
		ovw <= 1'b0;
		sx(rb ^ 8'hA5, 8);
		chk("overflow", 8'h01, ovf);
		chk("kept", tx, dbuf);
		chk("echo", tx, i_ssp_spi_partner.m_rx);
		clr();
		sx(8'hFF, 3);
		chk("abort", 8'h00, {sdo_oe, busy});
		sx(rb, 8);
		chk("resync", rb, dbuf);
		clr();
		cfg(MODE_SLV_FREE, 1'($urandom), 1'b1, 1'b0);
		sx(tx, 8);
		chk("free rx", tx, dbuf);
		stop_test();
	end
endmodule : tb_ssp_spi_port
